// [pkg/rxcdr_defines.vh]
// constants for the receive clock recovery reference and lock controller
`ifndef RXCDR_DEFINES_VH
`define RXCDR_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define RXCDR_ADDR_CTRL 4'h0
`define RXCDR_ADDR_STATUS 4'h4
`define RXCDR_ADDR_FREQ 4'h8

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RXCDR_CTRL_REMOTE_LOOP 0
`define RXCDR_CTRL_FORCE_REF 1
`define RXCDR_ST_ON_DATA 0
`define RXCDR_ST_LOS 1
`define RXCDR_ST_EXT_LOSS 2
`define RXCDR_ST_FREQ_OK 3
`define RXCDR_ST_BYPASS 4
`define RXCDR_ST_MUTE 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RXCDR_CTRL_RST 2'h0
`define RXCDR_PIN_RST 8'h00

// ----------------------------------------------------------------
// reference and rate figures
// ----------------------------------------------------------------
`define RXCDR_REF_HI_KHZ 77760
`define RXCDR_REF_LO_KHZ 19440
`define RXCDR_RATE_HI_KBPS 622080
`define RXCDR_RATE_LO_KBPS 155520
`define RXCDR_WORD_BITS 8

// ----------------------------------------------------------------
// timing counts (in recovered bit periods or reference periods)
// ----------------------------------------------------------------
`define RXCDR_LOS_ZERO_RUN 128
`define RXCDR_LOS_WINDOW 128
`define RXCDR_LOS_CLEAR_TRANS 16
`define RXCDR_WORD_STAGES 3
`define RXCDR_LOOP_DELAY 2
`define RXCDR_PPM_LIMIT 500
`define RXCDR_PPM_SHIFT 11
`define RXCDR_MEAS_WINDOW 8192

`endif

// [verilog/rxcdr_ctrl.v]
// receive clock recovery reference selection, lock sequencing, deserialiser and mute
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "rxcdr_defines.vh"

// Summary of operation
// - reference taken as 77.76 MHz when frequency select low, 19.44 MHz when high.
// - serial NRZ data accepted at 622.08 Mbps high rate, 155.52 Mbps low rate.
// - recovered bits deserialised into 8-bit words at one eighth of line rate.
// - parallel receive clock is the recovered bit clock divided by eight.
// - through mode: MSB reaches the parallel word 25 to 35 bit clocks later.
// - remote loopback: received MSB leaves transmit output 2 to 4 bit clocks later.
// - source select low trains on synthesizer reference, high on 77.76 MHz auxiliary.
// - after startup loop locks to reference first, then to incoming data.
// - recovered frequency off by over 500 ppm sends loop back to reference.
// - receive clock keeps running from the reference during loss of lock or signal.
// - external loss or internal loss of signal forces parallel word to zero.
// - relock to data needs no external loss, frequency within 500 ppm, no LOS.
// - bypass input disables recovery; timing comes from external recovered clock.
// - in bypass serial input is sampled on external clock rising edges.
module rxcdr_ctrl #(
  parameter MEAS_WINDOW = `RXCDR_MEAS_WINDOW,
  parameter CNT_W = 24
) (
  // clock and reset
  input wire I_MCLK,
  input wire I_RST_N,
  // configuration pins
  input wire I_REF_FREQ_SELECT,
  input wire I_LINE_RATE_SELECT,
  input wire I_RECOVERY_REF_SOURCE_SELECT,
  input wire I_RECOVERY_BYPASS,
  input wire I_EXTERNAL_SIGNAL_LOSS_IN_N,
  // serial side and clocks
  input wire I_RX_SERIAL_IN,
  input wire I_EXTERNAL_RECOVERED_CLOCK,
  input wire I_VCO_CLOCK,
  input wire I_SYNTH_REF_CLOCK,
  input wire I_AUX_RECOVERY_REF_CLOCK,
  // register port
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  // parallel side and status
  output reg [7:0] O_RX_PARALLEL_WORD,
  output reg O_RX_PCLK,
  output reg O_TX_SERIAL_OUT,
  output wire O_LOOP_ON_DATA,
  output wire O_REF_IS_LOW_FREQ,
  output wire O_AUX_REF_IN_USE,
  output reg O_LOS,
  output reg O_FREQ_OK
);

  // ----------------------------------------------------------------
  // pin indices and states
  // ----------------------------------------------------------------
  localparam P_FSEL = 0;
  localparam P_RATE = 1;
  localparam P_SRC = 2;
  localparam P_BYP = 3;
  localparam P_LOSN = 4;
  localparam P_SER = 5;
  localparam P_XCLK = 6;
  localparam P_VCO = 7;
  localparam NPIN = 10;
  localparam P_REF = 8;
  localparam P_AUX = 9;
  localparam [2:0] ST_REF = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_BYP = 3'b100;
  localparam [CNT_W-1:0] WIN = MEAS_WINDOW;

  wire [NPIN-1:0] pins;
  reg [NPIN-1:0] s1;
  reg [NPIN-1:0] s2;
  reg [NPIN-1:0] s3;
  reg [NPIN-1:0] flt;
  reg [NPIN-1:0] flt_d;
  wire [NPIN-1:0] agree;

  assign pins = {I_AUX_RECOVERY_REF_CLOCK, I_SYNTH_REF_CLOCK, I_VCO_CLOCK,
                 I_EXTERNAL_RECOVERED_CLOCK, I_RX_SERIAL_IN, I_EXTERNAL_SIGNAL_LOSS_IN_N,
                 I_RECOVERY_BYPASS, I_RECOVERY_REF_SOURCE_SELECT, I_LINE_RATE_SELECT,
                 I_REF_FREQ_SELECT};
  assign agree = ~(s2 ^ s3);

  // ----------------------------------------------------------------
  // pin synchronisers: a level counts once stages two and three agree
  // ----------------------------------------------------------------
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s1 <= {NPIN{1'b0}};
      s2 <= {NPIN{1'b0}};
      s3 <= {NPIN{1'b0}};
      flt <= {NPIN{1'b0}};
      flt_d <= {NPIN{1'b0}};
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      flt <= (agree & s3) | (~agree & flt);
      flt_d <= flt;
    end
  end

  // ----------------------------------------------------------------
  // clock and reference selection
  // ----------------------------------------------------------------
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] ctrl;
  wire bypass = flt[P_BYP];
  wire ext_loss = ~flt[P_LOSN];
  wire aux_sel = flt[P_SRC];
  // bypass takes external clock edges; otherwise the loop's own oscillator
  wire bit_tick = bypass ? (flt[P_XCLK] & ~flt_d[P_XCLK]) :
                  (flt[P_VCO] & ~flt_d[P_VCO]);
  // auxiliary source ignores the frequency select pin
  wire ref_tick = aux_sel ? (flt[P_AUX] & ~flt_d[P_AUX]) :
                  (flt[P_REF] & ~flt_d[P_REF]);
  wire ref_low = ~aux_sel & flt[P_FSEL];
  wire bit_in = flt[P_SER];

  assign O_REF_IS_LOW_FREQ = ref_low;
  assign O_AUX_REF_IN_USE = aux_sel;
  assign O_LOOP_ON_DATA = state[1];

  // bits per reference period as a power of two: 77.76 MHz gives 2 or 8,
  // 19.44 MHz gives 8 or 32 (line rate pin high selects the fast rate)
  function [2:0] ratio_shift;
    input lowf;
    input hirate;
    begin
      ratio_shift = {1'b0, hirate, 1'b1} + (lowf ? 3'h2 : 3'h0);
    end
  endfunction

  // ----------------------------------------------------------------
  // frequency measurement over a fixed reference window
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] ref_cnt;
  reg [CNT_W-1:0] bit_cnt_meas;
  reg [CNT_W-1:0] freq_last;
  wire [CNT_W-1:0] exp_bits = WIN << ratio_shift(ref_low, flt[P_RATE]);
  wire [CNT_W-1:0] diff = (bit_cnt_meas > exp_bits) ? (bit_cnt_meas - exp_bits) :
                          (exp_bits - bit_cnt_meas);
  // shift of eleven gives a limit of about 488 ppm, no divider needed
  wire [CNT_W-1:0] limit = exp_bits >> `RXCDR_PPM_SHIFT;

  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ref_cnt <= {CNT_W{1'b0}};
      bit_cnt_meas <= {CNT_W{1'b0}};
      freq_last <= {CNT_W{1'b0}};
      O_FREQ_OK <= 1'b0;
    end else if (ref_tick && ref_cnt == WIN - 1'b1) begin
      ref_cnt <= {CNT_W{1'b0}};
      bit_cnt_meas <= {{(CNT_W-1){1'b0}}, bit_tick};
      freq_last <= bit_cnt_meas;
      O_FREQ_OK <= (diff <= limit);
    end else begin
      ref_cnt <= ref_cnt + {{(CNT_W-1){1'b0}}, ref_tick};
      bit_cnt_meas <= bit_cnt_meas + {{(CNT_W-1){1'b0}}, bit_tick};
    end
  end

  // ----------------------------------------------------------------
  // lock sequencing: reference first, data only when all is clean
  // ----------------------------------------------------------------
  always @* begin
    next_state = state;
    case (state)
      ST_REF: begin
        if (bypass)
          next_state = ST_BYP;
        else if (O_FREQ_OK && !ext_loss && !O_LOS && !ctrl[`RXCDR_CTRL_FORCE_REF])
          next_state = ST_DATA;
      end
      ST_DATA: begin
        if (bypass)
          next_state = ST_BYP;
        else if (!O_FREQ_OK || ext_loss || O_LOS || ctrl[`RXCDR_CTRL_FORCE_REF])
          next_state = ST_REF;
      end
      ST_BYP: begin
        if (!bypass)
          next_state = ST_REF;
      end
      default: next_state = ST_REF;
    endcase
  end

  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N)
      state <= ST_REF;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // internal loss of signal over the recovered bit stream
  // ----------------------------------------------------------------
  reg [7:0] zero_run;
  reg [7:0] trans_cnt;
  reg [`RXCDR_LOS_WINDOW-1:0] trans_hist;
  reg prev_bit;
  wire trans = bit_in ^ prev_bit;
  wire [7:0] next_trans_cnt = trans_cnt + {7'h00, trans} -
                              {7'h00, trans_hist[`RXCDR_LOS_WINDOW-1]};

  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      zero_run <= 8'h00;
      trans_cnt <= 8'h00;
      trans_hist <= {`RXCDR_LOS_WINDOW{1'b0}};
      prev_bit <= 1'b0;
      O_LOS <= 1'b0;
    end else if (bit_tick) begin
      prev_bit <= bit_in;
      trans_hist <= {trans_hist[`RXCDR_LOS_WINDOW-2:0], trans};
      trans_cnt <= next_trans_cnt;
      if (bit_in)
        zero_run <= 8'h00;
      else if (zero_run != 8'hff)
        zero_run <= zero_run + 8'h01;
      if (!bit_in && zero_run == `RXCDR_LOS_ZERO_RUN - 1)
        O_LOS <= 1'b1;
      else if (O_LOS && next_trans_cnt >= `RXCDR_LOS_CLEAR_TRANS)
        O_LOS <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // deserialiser, parallel clock and remote loopback
  // ----------------------------------------------------------------
  wire mute = ext_loss | O_LOS;
  reg [2:0] bit_pos;
  reg [7:0] shreg;
  reg [7:0] stage [0:`RXCDR_WORD_STAGES-1];
  reg [`RXCDR_LOOP_DELAY-1:0] loop_dly;
  integer k;

  // the word pipeline sets the through latency at 31 bit periods
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bit_pos <= 3'h0;
      shreg <= 8'h00;
      for (k = 0; k < `RXCDR_WORD_STAGES; k = k + 1)
        stage[k] <= 8'h00;
      O_RX_PARALLEL_WORD <= 8'h00;
      O_RX_PCLK <= 1'b0;
    end else begin
      if (bit_tick) begin
        bit_pos <= bit_pos + 3'h1;
        shreg <= {shreg[6:0], bit_in};
        O_RX_PCLK <= ~bit_pos[2] ^ (bit_pos == 3'h3) ^ (bit_pos == 3'h7);
        if (bit_pos == 3'h7) begin
          stage[0] <= {shreg[6:0], bit_in};
          for (k = 1; k < `RXCDR_WORD_STAGES; k = k + 1)
            stage[k] <= stage[k-1];
          O_RX_PARALLEL_WORD <= mute ? 8'h00 : stage[`RXCDR_WORD_STAGES-1];
        end
      end
      if (mute)
        O_RX_PARALLEL_WORD <= 8'h00;
    end
  end

  // loopback retransmits two bit periods after arrival, muted on loss
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      loop_dly <= {`RXCDR_LOOP_DELAY{1'b0}};
      O_TX_SERIAL_OUT <= 1'b0;
    end else if (bit_tick) begin
      loop_dly <= {loop_dly[`RXCDR_LOOP_DELAY-2:0], bit_in};
      O_TX_SERIAL_OUT <= ctrl[`RXCDR_CTRL_REMOTE_LOOP] & ~mute &
                         loop_dly[`RXCDR_LOOP_DELAY-1];
    end
  end

  // ----------------------------------------------------------------
  // register port: reads answer one cycle later, unmapped reads zero
  // ----------------------------------------------------------------
  always @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctrl <= `RXCDR_CTRL_RST;
      O_RDATA <= 32'h00000000;
    end else begin
      if (I_WR && I_ADDR == `RXCDR_ADDR_CTRL)
        ctrl <= I_WDATA[1:0];
      O_RDATA <= 32'h00000000;
      if (I_RD) begin
        case (I_ADDR)
          `RXCDR_ADDR_CTRL: O_RDATA <= {30'h00000000, ctrl};
          `RXCDR_ADDR_STATUS: O_RDATA <= {26'h0000000, mute, bypass, O_FREQ_OK,
                                          ext_loss, O_LOS, state[1]};
          `RXCDR_ADDR_FREQ: O_RDATA <= {{(32-CNT_W){1'b0}}, freq_last};
          default: O_RDATA <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // rxcdr_ctrl

// [tb/rxcdr_ctrl_properties.sv]
// port assertions for the recovery controller
`timescale 1ns/100ps
module rxcdr_ctrl_properties (
  // watched ports
  input wire I_MCLK,
  input wire I_RST_N,
  input wire I_REF_FREQ_SELECT,
  input wire I_RECOVERY_REF_SOURCE_SELECT,
  input wire I_RECOVERY_BYPASS,
  input wire I_EXTERNAL_SIGNAL_LOSS_IN_N,
  input wire [7:0] O_RX_PARALLEL_WORD,
  input wire O_RX_PCLK,
  input wire O_LOOP_ON_DATA,
  input wire O_REF_IS_LOW_FREQ,
  input wire O_AUX_REF_IN_USE,
  input wire O_LOS,
  input wire O_FREQ_OK
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  // pins pass a four-edge filter, so six samples means a change has landed
  sequence s_loss;
    !I_EXTERNAL_SIGNAL_LOSS_IN_N [*6];
  endsequence
  sequence s_byp;
    I_RECOVERY_BYPASS [*6];
  endsequence
  a_mute_ext_loss: assert property (s_loss |-> O_RX_PARALLEL_WORD == 8'h00)
    else $error("word not muted on external loss");
  a_mute_int_los: assert property (O_LOS [*2] |-> O_RX_PARALLEL_WORD == 8'h00)
    else $error("word not muted on signal loss");
  a_loss_no_lock: assert property (s_loss |-> !O_LOOP_ON_DATA)
    else $error("data lock during external loss");
  a_bypass_no_lock: assert property (s_byp |-> !O_LOOP_ON_DATA)
    else $error("data lock while bypassed");
  a_ref_fallback: assert property ((!O_FREQ_OK || O_LOS) |=> !O_LOOP_ON_DATA)
    else $error("data lock kept on bad frequency");
  a_ref_freq_pin: assert property (
    ($stable(I_REF_FREQ_SELECT) && $stable(I_RECOVERY_REF_SOURCE_SELECT) &&
     !I_RECOVERY_REF_SOURCE_SELECT) [*6] |-> O_REF_IS_LOW_FREQ == I_REF_FREQ_SELECT)
    else $error("reference frequency flag wrong");
  // the auxiliary source is always the fast reference, whatever the select pin says
  a_aux_fsel_ignored: assert property (I_RECOVERY_REF_SOURCE_SELECT [*6] |-> !O_REF_IS_LOW_FREQ)
    else $error("low reference flagged while aux source in use");
  a_aux_src_pin: assert property (
    $stable(I_RECOVERY_REF_SOURCE_SELECT) [*6] |-> O_AUX_REF_IN_USE == I_RECOVERY_REF_SOURCE_SELECT)
    else $error("aux reference flag wrong");
  a_pclk_div8: assert property ($rose(O_RX_PCLK) |=> O_RX_PCLK [*8])
    else $error("parallel clock high too short");
endmodule // rxcdr_ctrl_properties
bind rxcdr_ctrl rxcdr_ctrl_properties rxcdr_ctrl_properties_i (.I_MCLK(I_MCLK),
  .I_RST_N(I_RST_N), .I_REF_FREQ_SELECT(I_REF_FREQ_SELECT),
  .I_RECOVERY_REF_SOURCE_SELECT(I_RECOVERY_REF_SOURCE_SELECT),
  .I_RECOVERY_BYPASS(I_RECOVERY_BYPASS), .I_EXTERNAL_SIGNAL_LOSS_IN_N(I_EXTERNAL_SIGNAL_LOSS_IN_N),
  .O_RX_PARALLEL_WORD(O_RX_PARALLEL_WORD), .O_RX_PCLK(O_RX_PCLK), .O_LOOP_ON_DATA(O_LOOP_ON_DATA),
  .O_REF_IS_LOW_FREQ(O_REF_IS_LOW_FREQ), .O_AUX_REF_IN_USE(O_AUX_REF_IN_USE), .O_LOS(O_LOS),
  .O_FREQ_OK(O_FREQ_OK));

// [tb/rxcdr_optic_model.sv]
// optical module model: bit clock, serial bytes and reference clocks
`timescale 1ns/100ps
module rxcdr_optic_model (
  // clock and control
  input wire i_clk,
  input wire i_rst_n,
  input wire i_run,
  input wire i_bypass,
  input wire [7:0] i_next_byte,
  // lines to the device
  output reg o_load,
  output reg o_ser,
  output wire o_vco_clk,
  output wire o_ext_clk,
  output wire o_synth_ref,
  output wire o_aux_ref
);
  reg [2:0] cnt;
  reg [2:0] bi;
  reg [6:0] sh;
  // bit clock is 4 cycles, reference 8: exactly two bits per reference tick
  assign o_vco_clk = cnt[1] & ~i_bypass;
  assign o_ext_clk = cnt[1] & i_bypass;
  assign o_synth_ref = cnt[2];
  assign o_aux_ref = ~cnt[2];
  // bits change while the clock is low and hold past the next rise
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {cnt, bi, sh, o_ser, o_load} <= 15'h0000;
    end else begin
      o_load <= 1'b0;
      if (i_run) begin
        cnt <= cnt + 3'h1;
        if (cnt[1:0] == 2'h0) begin
          bi <= bi + 3'h1;
          o_load <= (bi == 3'h0);
          o_ser <= (bi == 3'h0) ? i_next_byte[7] : sh[6]; // msb first
          sh <= (bi == 3'h0) ? i_next_byte[6:0] : {sh[5:0], 1'b0};
        end
      end
    end
  end
endmodule // rxcdr_optic_model

// [tb/rxcdr_ctrl_tb_top.sv]
// bench for the recovery controller
`timescale 1ns/100ps
module rxcdr_ctrl_tb_top;
  reg clk, rst_n, fsel, rsel, ssel, byp, loss_n, run, wr, rd, chk_on, rnd_on, pclk_d, e;
  reg lp_on;
  reg [13:0] ser_h;
  reg [3:0] addr;
  reg [31:0] wdata;
  reg [7:0] nxt, fill;
  reg [7:0] exp_q [$];
  wire [31:0] rdata;
  wire [7:0] word;
  wire pclk, txo, on_data, lowf, aux, los, fok, load, vco, xclk, ser, sref, aref;
  integer seed, n_fail, check_count, i, rnd;
  rxcdr_ctrl #(.MEAS_WINDOW(64)) rxcdr_ctrl_i (.I_MCLK(clk), .I_RST_N(rst_n),
    .I_REF_FREQ_SELECT(fsel), .I_LINE_RATE_SELECT(rsel), .I_RECOVERY_REF_SOURCE_SELECT(ssel),
    .I_RECOVERY_BYPASS(byp), .I_EXTERNAL_SIGNAL_LOSS_IN_N(loss_n), .I_RX_SERIAL_IN(ser),
    .I_EXTERNAL_RECOVERED_CLOCK(xclk), .I_VCO_CLOCK(vco), .I_SYNTH_REF_CLOCK(sref),
    .I_AUX_RECOVERY_REF_CLOCK(aref), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdata), .O_RX_PARALLEL_WORD(word), .O_RX_PCLK(pclk), .O_TX_SERIAL_OUT(txo),
    .O_LOOP_ON_DATA(on_data), .O_REF_IS_LOW_FREQ(lowf), .O_AUX_REF_IN_USE(aux), .O_LOS(los),
    .O_FREQ_OK(fok));
  rxcdr_optic_model rxcdr_optic_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_run(run),
    .i_bypass(byp), .i_next_byte(nxt), .o_load(load), .o_ser(ser), .o_vco_clk(vco),
    .o_ext_clk(xclk), .o_synth_ref(sref), .o_aux_ref(aref));
  task chk(input string nm, input [31:0] x, input [31:0] s);
    begin
      check_count = check_count + 1;
      if (s !== x) begin
        n_fail = n_fail + 1;
        $display("ERROR %0s expected %h seen %h", nm, x, s);
      end
    end
  endtask
  task wt(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task rdchk(input [3:0] a, input [31:0] m, input [31:0] x);
    begin
      @(posedge clk);
      {addr, rd} <= {a, 1'b1};
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("read data", x, rdata & m);
    end
  endtask
  task wrr(input [31:0] d);
    begin
      @(posedge clk);
      {addr, wdata, wr} <= {4'h0, d, 1'b1};
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // each byte the model takes while checking is a word expected back
  always @(posedge clk) begin
    if (load === 1'b1) begin
      if (chk_on) exp_q.push_back(nxt);
      rnd = $random(seed);
      nxt <= rnd_on ? rnd[7:0] : fill;
    end
  end
  // words are compared as the parallel clock rises
  always @(posedge clk) begin
    pclk_d <= pclk;
    if (pclk === 1'b1 && pclk_d === 1'b0 && exp_q.size() > 0)
      chk("rx word", exp_q.pop_front(), word);
  end
  // loopback bits come back fourteen clocks after the model drives them:
  // a four-clock filter, two clocks to the filtered bit clock rise, then two bit periods of delay
  always @(posedge clk) begin
    ser_h <= {ser_h[12:0], ser};
    if (lp_on === 1'b1) chk("loop bit", ser_h[13], txo);
  end
  // the sequence needs about 12400 cycles
  initial begin
    #2000000;
    n_fail = n_fail + 1;
    results;
  end
  initial begin
    seed = 77619;
    {n_fail, check_count} = 0;
    {rst_n, fsel, rsel, ssel, byp, run, wr, rd, chk_on, pclk_d, addr, wdata} = 46'h0;
    {loss_n, rnd_on, nxt, fill} = 18'h3a5ff;
    lp_on = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(4'h0, 32'hffffffff, 32'h0);
    rdchk(4'hc, 32'hffffffff, 32'h0);
    $display("reset test done");
    // the first bit tick raises the parallel clock once more, so four
    // zero words show before the first byte has crossed the pipe
    repeat (4) exp_q.push_back(8'h00);
    @(posedge clk) {chk_on, run} <= 2'h3;
    repeat (30) @(posedge load);
    chk_on <= 1'b0;
    for (i = 0; i < 400 && exp_q.size() > 0; i = i + 1) @(posedge clk);
    chk("words left", 0, exp_q.size());
    $display("through test done");
    for (i = 7; i >= 0; i = i - 1) begin
      @(posedge clk) {ssel, fsel, rsel} <= i[2:0];
      e = !i[0] && (i[2] || !i[1]);
      wt(1200);
      chk("freq ok", e, fok);
      chk("on data", e, on_data);
      chk("aux ref", i[2], aux);
      if (!i[2]) chk("low ref", i[1], lowf);
    end
    // 64 reference ticks at two model bits per tick
    rdchk(4'h8, 32'hffffffff, 32'h80);
    $display("reference test done");
    @(posedge clk) loss_n <= 1'b0;
    wt(20);
    chk("muted word", 0, word);
    chk("on data", 0, on_data);
    rdchk(4'h4, 32'h4, 32'h4);
    e = pclk;
    for (i = 0; i < 100 && pclk === e; i = i + 1) wt(1);
    chk("pclk moves", 1, pclk !== e);
    @(posedge clk) loss_n <= 1'b1;
    wt(60);
    chk("on data", 1, on_data);
    $display("loss test done");
    wrr(32'h1);
    wt(40);
    lp_on = 1'b1;
    wt(200);
    lp_on = 1'b0;
    @(posedge clk) rnd_on <= 1'b0;
    wt(160);
    chk("loop out", 1, txo);
    wrr(32'h2);
    wt(10);
    chk("forced ref", 0, on_data);
    wrr(32'h0);
    wt(10);
    chk("loop off", 0, txo);
    chk("on data", 1, on_data);
    $display("loopback test done");
    @(posedge clk) {byp, fill} <= 9'h100;
    wt(20);
    chk("on data", 0, on_data);
    rdchk(4'h4, 32'h10, 32'h10);
    wt(700);
    chk("los", 1, los);
    chk("muted word", 0, word);
    @(posedge clk) rnd_on <= 1'b1;
    wt(300);
    chk("los", 0, los);
    $display("bypass test done");
    results;
  end
endmodule // rxcdr_ctrl_tb_top
